// ---- hw/sfcf_top.sv ----
// Serial flash command front end: link shifter, decoder, buffers, protection, busy
`timescale 1ns/1ps
`default_nettype none

module sfcf_top #(
  parameter int BUF_BYTES = 528,
  parameter int SECT_BITS = 4,
  parameter logic POW2_DEFAULT = 1'b0
) (
  // System clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Serial link
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Hardware protect and ready/busy pins
  input wire logic wp_n_i,
  output logic rdy_busy_o,
  output logic rdy_busy_oe_o,
  // Array engine: self-timed operations
  output logic op_start_o,
  output sfcf_pkg::sfcf_kind_t op_kind_o,
  output logic [11:0] op_page_o,
  output logic op_buf_o,
  input wire logic op_done_i,
  // Array engine: access to the buffer in use
  input wire logic [9:0] eng_idx_i,
  input wire logic eng_we_i,
  input wire logic [7:0] eng_wdata_i,
  output logic [7:0] eng_rdata_o,
  // Array read port, data one cycle after the enable
  output logic array_rd_en_o,
  output logic [21:0] array_rd_addr_o,
  input wire logic [7:0] array_rd_data_i,
  // Status
  output logic page_pow2_o,
  output logic sw_prot_en_o
);

  localparam int NSECT = 1 << SECT_BITS;
  localparam logic [9:0] BUF_LAST = 10'(BUF_BYTES - 1);

  typedef struct packed {
    logic [5:0] cnt;
    logic [2:0] bcnt;
    logic [31:0] sh;
    logic [31:0] hdr;
    logic hdr_valid;
  } sfcf_frame_t;

  typedef struct packed {
    logic adv_tog;
    logic wr_tog;
    logic [7:0] rx_byte;
  } sfcf_tog_t;

  typedef struct packed {
    logic [7:0] tx_sh;
    logic tx_act;
  } sfcf_tx_t;

  typedef struct packed {
    sfcf_pkg::sfcf_state_t state;
    logic [1:0] cs_s;
    logic [1:0] wp_s;
    logic [2:0] hdr_s;
    logic [2:0] adv_s;
    logic [2:0] wr_s;
    logic [7:0] cmd;
    logic [11:0] page;
    logic [9:0] byte_ofs;
    logic [9:0] bidx;
    logic blocked;
    logic start_pend;
    logic busy;
    logic buf_used;
    logic busy_buf;
    logic op_start;
    sfcf_pkg::sfcf_kind_t op_kind;
    logic pow2;
    logic sw_prot_en;
    logic [NSECT-1:0] prot_tbl;
    logic [NSECT-1:0] lock_tbl;
    logic [7:0] rd_data;
    logic [7:0] eng_rdata;
    logic arr_fetch;
    logic arr_wait;
    logic [1:0][BUF_BYTES-1:0][7:0] mem;
  } sfcf_sys_t;

  function automatic logic is_rd(input logic [7:0] op);
    return (op == sfcf_pkg::OP_BUF1_RD) || (op == sfcf_pkg::OP_BUF2_RD)
      || (op == sfcf_pkg::OP_ARR_RD);
  endfunction : is_rd

  function automatic logic [9:0] wrap_idx(input logic [9:0] i, input logic p2);
    return (i == (p2 ? sfcf_pkg::LAST_512 : sfcf_pkg::LAST_528)) ? 10'h000 : i + 10'h001;
  endfunction : wrap_idx

  sfcf_frame_t f, next_f;
  sfcf_tog_t t, next_t;
  sfcf_tx_t o, next_o;
  sfcf_sys_t s, next_s;
  logic link_rst;

  // Deselect or device reset clears the frame at once, even with the clock parked
  assign link_rst = cs_n_i | ~rst_n_i;

  // Link side, rising edge: opcode, address and write data shift in
  always_comb
  begin
    next_f = f;
    next_f.sh = {f.sh[30:0], si_i};
    if (f.cnt != sfcf_pkg::HDR_DONE)
    begin
      next_f.cnt = f.cnt + 6'h01;
    end
    if (f.cnt == sfcf_pkg::HDR_LAST)
    begin
      next_f.hdr = {f.sh[30:0], si_i};
      next_f.hdr_valid = 1'b1;
    end
    if (f.cnt == sfcf_pkg::HDR_DONE)
    begin
      next_f.bcnt = f.bcnt + 3'h1;
    end
  end

  always_ff @(posedge sck_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      f <= '0;
    end
    else
    begin
      f <= next_f;
    end
  end

  // Toggles survive the frame reset so the system side never sees a false event
  always_comb
  begin
    next_t = t;
    if (f.cnt == sfcf_pkg::HDR_DONE && f.bcnt == sfcf_pkg::BIT_FIRST)
    begin
      next_t.adv_tog = ~t.adv_tog;
    end
    if (f.cnt == sfcf_pkg::HDR_DONE && f.bcnt == sfcf_pkg::BIT_LAST)
    begin
      next_t.rx_byte = {f.sh[6:0], si_i};
      next_t.wr_tog = ~t.wr_tog;
    end
  end

  always_ff @(posedge sck_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      t <= '0;
    end
    else
    begin
      t <= next_t;
    end
  end

  // Link side, falling edge: read data shifts out; rd_data is steady for a whole byte
  always_comb
  begin
    next_o = o;
    if (f.cnt == sfcf_pkg::HDR_DONE && f.bcnt == sfcf_pkg::BIT_FIRST && is_rd(f.hdr[31:24]))
    begin
      next_o.tx_sh = s.rd_data;
      next_o.tx_act = 1'b1;
    end
    else
    begin
      next_o.tx_sh = {o.tx_sh[6:0], 1'b0};
    end
  end

  always_ff @(negedge sck_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      o <= '0;
    end
    else
    begin
      o <= next_o;
    end
  end

  assign so_o = o.tx_sh[7];
  assign so_oe_o = o.tx_act;

  // System side
  logic [7:0] op;
  logic [23:0] a;
  logic [11:0] pg;
  logic [9:0] by;
  logic bsel;
  logic pe;
  logic hit;
  logic wp_on;
  logic hdr_rise;
  logic adv_ev;
  logic wr_ev;
  logic [9:0] nidx;
  logic [SECT_BITS-1:0] sect;

  always_comb
  begin
    next_s = s;
    op = f.hdr[31:24];
    a = f.hdr[23:0];
    pg = s.pow2 ? a[20:9] : a[21:10];
    by = s.pow2 ? {1'b0, a[8:0]} : a[9:0];
    bsel = op[1];
    pe = (op == sfcf_pkg::OP_PROG1) || (op == sfcf_pkg::OP_PROG2)
      || (op >= sfcf_pkg::OP_ER_PAGE && op <= sfcf_pkg::OP_ER_CHIP);
    sect = pg[11 -: SECT_BITS];
    wp_on = ~s.wp_s[1];
    hit = (op == sfcf_pkg::OP_ER_CHIP)
      ? |((s.prot_tbl & {NSECT{s.sw_prot_en | wp_on}}) | s.lock_tbl)
      : ((s.sw_prot_en | wp_on) & s.prot_tbl[sect]) | s.lock_tbl[sect];
    hdr_rise = s.hdr_s[1] & ~s.hdr_s[2];
    adv_ev = s.adv_s[1] ^ s.adv_s[2];
    wr_ev = s.wr_s[1] ^ s.wr_s[2];
    nidx = wrap_idx(s.bidx, s.pow2);

    next_s.cs_s = {s.cs_s[0], cs_n_i};
    next_s.wp_s = {s.wp_s[0], wp_n_i};
    next_s.hdr_s = {s.hdr_s[1:0], f.hdr_valid};
    next_s.adv_s = {s.adv_s[1:0], t.adv_tog};
    next_s.wr_s = {s.wr_s[1:0], t.wr_tog};
    next_s.op_start = 1'b0;
    next_s.arr_fetch = 1'b0;
    next_s.arr_wait = s.arr_fetch;
    if (s.arr_wait)
    begin
      next_s.rd_data = array_rd_data_i;
    end

    // Engine owns the buffer in use while busy
    if (s.busy && s.buf_used && eng_we_i && eng_idx_i <= BUF_LAST)
    begin
      next_s.mem[s.busy_buf][eng_idx_i] = eng_wdata_i;
    end
    next_s.eng_rdata = (eng_idx_i <= BUF_LAST) ? s.mem[s.busy_buf][eng_idx_i]
      : sfcf_pkg::BLOCKED_BYTE;
    if (s.busy && op_done_i)
    begin
      next_s.busy = 1'b0;
    end

    if (hdr_rise)
    begin
      next_s.cmd = op;
      next_s.page = pg;
      next_s.byte_ofs = by;
      next_s.bidx = by;
      next_s.start_pend = 1'b0;
      next_s.blocked = 1'b0;
      next_s.state = sfcf_pkg::SFCF_ST_SERVE;
      case (op)
        sfcf_pkg::OP_BUF1_RD, sfcf_pkg::OP_BUF2_RD:
        begin
          next_s.blocked = s.busy && s.buf_used && (s.busy_buf == bsel);
          next_s.rd_data = next_s.blocked ? sfcf_pkg::BLOCKED_BYTE : s.mem[bsel][by];
        end
        sfcf_pkg::OP_BUF1_WR, sfcf_pkg::OP_BUF2_WR:
        begin
          next_s.blocked = s.busy && s.buf_used && (s.busy_buf == bsel);
        end
        sfcf_pkg::OP_ARR_RD:
        begin
          next_s.blocked = s.busy;
          next_s.arr_fetch = ~s.busy;
          next_s.rd_data = sfcf_pkg::BLOCKED_BYTE;
        end
        sfcf_pkg::OP_PROG1, sfcf_pkg::OP_PROG2, sfcf_pkg::OP_XFER1, sfcf_pkg::OP_XFER2,
        sfcf_pkg::OP_CMP1, sfcf_pkg::OP_CMP2, sfcf_pkg::OP_ER_PAGE, sfcf_pkg::OP_ER_BLOCK,
        sfcf_pkg::OP_ER_SECTOR, sfcf_pkg::OP_ER_CHIP:
        begin
          if (s.busy || (pe && (wp_on || hit)))
          begin
            next_s.state = sfcf_pkg::SFCF_ST_DISCARD;
          end
          else
          begin
            next_s.start_pend = 1'b1;
          end
        end
        sfcf_pkg::OP_PROT_EN:
        begin
          next_s.sw_prot_en = 1'b1;
        end
        sfcf_pkg::OP_PROT_DIS:
        begin
          next_s.sw_prot_en = 1'b0;
        end
        sfcf_pkg::OP_PROT_WR:
        begin
          next_s.bidx = 10'h000;
          if (wp_on)
          begin
            next_s.state = sfcf_pkg::SFCF_ST_DISCARD;
          end
        end
        sfcf_pkg::OP_LOCK:
        begin
          next_s.lock_tbl[sect] = 1'b1;
        end
        sfcf_pkg::OP_POW2_ON:
        begin
          next_s.pow2 = 1'b1;
        end
        sfcf_pkg::OP_POW2_OFF:
        begin
          next_s.pow2 = 1'b0;
        end
        default:
        begin
          next_s.state = sfcf_pkg::SFCF_ST_DISCARD;
        end
      endcase
      // Programming always takes the whole page of the chosen buffer
      case (op)
        sfcf_pkg::OP_PROG1, sfcf_pkg::OP_PROG2: next_s.op_kind = sfcf_pkg::SFCF_K_PROG;
        sfcf_pkg::OP_XFER1, sfcf_pkg::OP_XFER2: next_s.op_kind = sfcf_pkg::SFCF_K_XFER;
        sfcf_pkg::OP_CMP1, sfcf_pkg::OP_CMP2: next_s.op_kind = sfcf_pkg::SFCF_K_CMP;
        sfcf_pkg::OP_ER_PAGE: next_s.op_kind = sfcf_pkg::SFCF_K_ER_PAGE;
        sfcf_pkg::OP_ER_BLOCK: next_s.op_kind = sfcf_pkg::SFCF_K_ER_BLOCK;
        sfcf_pkg::OP_ER_SECTOR: next_s.op_kind = sfcf_pkg::SFCF_K_ER_SECTOR;
        sfcf_pkg::OP_ER_CHIP: next_s.op_kind = sfcf_pkg::SFCF_K_ER_CHIP;
        default: next_s.op_kind = s.op_kind;
      endcase
    end
    else if (adv_ev && s.state == sfcf_pkg::SFCF_ST_SERVE && is_rd(s.cmd))
    begin
      // Prefetch the next byte while the current one shifts out
      if (s.cmd == sfcf_pkg::OP_ARR_RD)
      begin
        if (s.byte_ofs == (s.pow2 ? sfcf_pkg::LAST_512 : sfcf_pkg::LAST_528))
        begin
          next_s.byte_ofs = 10'h000;
          next_s.page = s.page + 12'h001;
        end
        else
        begin
          next_s.byte_ofs = s.byte_ofs + 10'h001;
        end
        next_s.arr_fetch = ~s.blocked;
      end
      else
      begin
        next_s.bidx = nidx;
        next_s.rd_data = s.blocked ? sfcf_pkg::BLOCKED_BYTE : s.mem[s.cmd[1]][nidx];
      end
    end

    // Write data may land just after chip select rises, so only the discard state is refused here
    if (wr_ev && !hdr_rise && s.state != sfcf_pkg::SFCF_ST_DISCARD)
    begin
      if ((s.cmd == sfcf_pkg::OP_BUF1_WR || s.cmd == sfcf_pkg::OP_BUF2_WR) && !s.blocked)
      begin
        next_s.mem[s.cmd[1]][s.bidx] = t.rx_byte;
        next_s.bidx = nidx;
      end
      else if (s.cmd == sfcf_pkg::OP_PROT_WR && !wp_on && s.bidx < 10'(NSECT))
      begin
        next_s.prot_tbl[s.bidx[SECT_BITS-1:0]] = |t.rx_byte;
        next_s.bidx = s.bidx + 10'h001;
      end
    end

    if (!hdr_rise && s.cs_s[1] && s.state != sfcf_pkg::SFCF_ST_IDLE)
    begin
      if (s.state == sfcf_pkg::SFCF_ST_SERVE && s.start_pend)
      begin
        next_s.busy = 1'b1;
        next_s.op_start = 1'b1;
        next_s.busy_buf = s.cmd[1];
        next_s.buf_used = (s.op_kind == sfcf_pkg::SFCF_K_PROG)
          || (s.op_kind == sfcf_pkg::SFCF_K_XFER) || (s.op_kind == sfcf_pkg::SFCF_K_CMP);
      end
      next_s.start_pend = 1'b0;
      next_s.state = sfcf_pkg::SFCF_ST_IDLE;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s <= '0;
      s.state <= sfcf_pkg::SFCF_ST_IDLE;
      s.cs_s <= sfcf_pkg::CS_SYNC_RST;
      s.wp_s <= sfcf_pkg::WP_SYNC_RST;
      s.pow2 <= POW2_DEFAULT;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign rdy_busy_o = 1'b0;
  assign rdy_busy_oe_o = s.busy;
  assign op_start_o = s.op_start;
  assign op_kind_o = s.op_kind;
  assign op_page_o = s.page;
  assign op_buf_o = s.busy_buf;
  assign eng_rdata_o = s.eng_rdata;
  assign array_rd_en_o = s.arr_fetch;
  assign array_rd_addr_o = s.pow2 ? {1'b0, s.page, s.byte_ofs[8:0]} : {s.page, s.byte_ofs};
  assign page_pow2_o = s.pow2;
  assign sw_prot_en_o = s.sw_prot_en;

endmodule : sfcf_top

`default_nettype wire

// ---- hw/sfcf_pkg.sv ----
// Constants, opcodes and types of the serial flash command front end
package sfcf_pkg;

  // Frame layout: 8 opcode bits then 24 address bits, then data bytes
  localparam logic [5:0] HDR_LAST = 6'h1f;
  localparam logic [5:0] HDR_DONE = 6'h20;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Last byte index of a page or buffer for each page size
  localparam logic [9:0] LAST_528 = 10'h20f;
  localparam logic [9:0] LAST_512 = 10'h1ff;

  // Byte shifted out for any access refused while busy
  localparam logic [7:0] BLOCKED_BYTE = 8'hff;

  // Reset values of the sampled pins (deselected, write protect released)
  localparam logic [1:0] CS_SYNC_RST = 2'h3;
  localparam logic [1:0] WP_SYNC_RST = 2'h3;

  // Opcodes; low nibble 1 addresses the first buffer, 2 the second
  localparam logic [7:0] OP_BUF1_RD = 8'h11;
  localparam logic [7:0] OP_BUF2_RD = 8'h12;
  localparam logic [7:0] OP_BUF1_WR = 8'h21;
  localparam logic [7:0] OP_BUF2_WR = 8'h22;
  localparam logic [7:0] OP_ARR_RD = 8'h30;
  localparam logic [7:0] OP_PROG1 = 8'h41;
  localparam logic [7:0] OP_PROG2 = 8'h42;
  localparam logic [7:0] OP_XFER1 = 8'h51;
  localparam logic [7:0] OP_XFER2 = 8'h52;
  localparam logic [7:0] OP_CMP1 = 8'h61;
  localparam logic [7:0] OP_CMP2 = 8'h62;
  localparam logic [7:0] OP_ER_PAGE = 8'h70;
  localparam logic [7:0] OP_ER_BLOCK = 8'h71;
  localparam logic [7:0] OP_ER_SECTOR = 8'h72;
  localparam logic [7:0] OP_ER_CHIP = 8'h73;
  localparam logic [7:0] OP_PROT_EN = 8'h80;
  localparam logic [7:0] OP_PROT_DIS = 8'h81;
  localparam logic [7:0] OP_PROT_WR = 8'h82;
  localparam logic [7:0] OP_LOCK = 8'h83;
  localparam logic [7:0] OP_POW2_ON = 8'h90;
  localparam logic [7:0] OP_POW2_OFF = 8'h91;

  // Self-timed operation handed to the array engine
  typedef enum logic [2:0] {
    SFCF_K_PROG = 3'h0,
    SFCF_K_XFER = 3'h1,
    SFCF_K_CMP = 3'h2,
    SFCF_K_ER_PAGE = 3'h3,
    SFCF_K_ER_BLOCK = 3'h4,
    SFCF_K_ER_SECTOR = 3'h5,
    SFCF_K_ER_CHIP = 3'h6
  } sfcf_kind_t;

  // Frame state of the system side
  typedef enum logic [2:0] {
    SFCF_ST_IDLE = 3'b001,
    SFCF_ST_SERVE = 3'b010,
    SFCF_ST_DISCARD = 3'b100
  } sfcf_state_t;

endpackage : sfcf_pkg

// ---- bench/sfcf_host.sv ----
// Host serial bus controller model that drives the flash link
`timescale 1ns/1ps
`default_nettype none
module sfcf_host (
  // Serial link
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  logic [7:0] tx [0:7];
  logic [7:0] rx [0:7];
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // Clock stands still between frames; mode 3 parks it high
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n, input logic m3);
    logic [31:0] hdr;
    int b;
    hdr = {op, a};
    sck_o = m3;
    #2.2 cs_n_o = 1'b0;
    #40 sck_o = 1'b0;
    for (int i = 0; i < 32 + 8 * n; i++)
    begin
      b = i - 32;
      si_o = (i < 32) ? hdr[31 - i] : tx[b / 8][7 - b % 8];
      #40 sck_o = 1'b1;
      // A disabled output reads as unknown so it can never match
      if (i >= 32) rx[b / 8][7 - b % 8] = (so_oe_i === 1'b1) ? so_i : 1'bx;
      #40 if (!(m3 && i == 31 + 8 * n)) sck_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    si_o = ~si_o;
    sck_o = m3;
    #60;
  endtask : frame
endmodule : sfcf_host
`default_nettype wire

// ---- bench/sfcf_chk.sv ----
// Port-level assertions of the serial flash command front end
`timescale 1ns/1ps
`default_nettype none
module sfcf_chk (
  // Clock, reset and inputs
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic wp_n_i,
  input wire logic op_done_i,
  // Outputs under watch
  input wire logic so_oe_o,
  input wire logic rdy_busy_o,
  input wire logic rdy_busy_oe_o,
  input wire logic op_start_o,
  input wire sfcf_pkg::sfcf_kind_t op_kind_o,
  input wire logic array_rd_en_o,
  input wire logic [21:0] array_rd_addr_o,
  input wire logic page_pow2_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic guarded;
  assign guarded = op_kind_o != sfcf_pkg::SFCF_K_XFER && op_kind_o != sfcf_pkg::SFCF_K_CMP;
  oe_desel_a: assert property (cs_n_i |-> !so_oe_o)
    else $error("serial output enabled while deselected");
  busy_start_a: assert property (op_start_o |-> rdy_busy_oe_o)
    else $error("operation started without busy");
  busy_cause_a: assert property ($rose(rdy_busy_oe_o) |-> op_start_o)
    else $error("busy raised without a start");
  busy_hold_a: assert property (rdy_busy_oe_o && !op_done_i |=> rdy_busy_oe_o)
    else $error("busy dropped before completion");
  busy_end_a: assert property (rdy_busy_oe_o && op_done_i |=> !rdy_busy_oe_o)
    else $error("busy kept after completion");
  pin_low_a: assert property (!rdy_busy_o)
    else $error("busy pin data not low");
  start_pulse_a: assert property (op_start_o |=> !op_start_o)
    else $error("start longer than one cycle");
  wp_block_a: assert property (op_start_o && guarded |-> wp_n_i)
    else $error("program or erase started under protect");
  rd_busy_a: assert property (rdy_busy_oe_o |-> !array_rd_en_o)
    else $error("array read while busy");
  bin_addr_a: assert property (array_rd_en_o && page_pow2_o |-> !array_rd_addr_o[21])
    else $error("binary address out of range");
  rst_idle_a: assert property ($rose(rst_n_i) |-> !rdy_busy_oe_o && !op_start_o && !so_oe_o)
    else $error("not idle after reset");
  start_c: cover property (op_start_o);
  done_c: cover property (rdy_busy_oe_o && op_done_i);
  bin_c: cover property (array_rd_en_o && page_pow2_o);
  out_c: cover property (so_oe_o ##1 cs_n_i);
endmodule : sfcf_chk
bind sfcf_top sfcf_chk chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .wp_n_i(wp_n_i),
  .op_done_i(op_done_i), .so_oe_o(so_oe_o), .rdy_busy_o(rdy_busy_o),
  .rdy_busy_oe_o(rdy_busy_oe_o), .op_start_o(op_start_o), .op_kind_o(op_kind_o),
  .array_rd_en_o(array_rd_en_o), .array_rd_addr_o(array_rd_addr_o),
  .page_pow2_o(page_pow2_o)
);
`default_nettype wire

// ---- bench/tb_serial_flash_command_frontend.sv ----
// Self-checking bench of the serial flash command front end
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_command_frontend;
  logic clock_i, rst_n_i, wp_n_i, op_done_i, eng_we_i;
  logic sck, cs_n, si, so, so_oe, busy_oe, op_start, rd_en, pow2, sw_prot, seen, op_buf;
  logic [9:0] eng_idx_i;
  logic [7:0] eng_wdata_i, eng_rdata, rd_data, v;
  logic [11:0] op_page, pg;
  logic [21:0] rd_addr, ea;
  logic [31:0] seed;
  logic [7:0] ex [0:7];
  logic [7:0] keep [0:1];
  logic [7:0] ops [0:6];
  sfcf_pkg::sfcf_kind_t op_kind;
  int errors, check_count, i, k;
  // The start pulse lands while the host still winds down its frame, so it is counted here
  int starts = 0;
  int taken = 0;
  sfcf_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));
  sfcf_top dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n_i), .rdy_busy_o(), .rdy_busy_oe_o(busy_oe),
    .op_start_o(op_start), .op_kind_o(op_kind), .op_page_o(op_page), .op_buf_o(op_buf),
    .op_done_i(op_done_i), .eng_idx_i(eng_idx_i), .eng_we_i(eng_we_i),
    .eng_wdata_i(eng_wdata_i), .eng_rdata_o(eng_rdata), .array_rd_en_o(rd_en),
    .array_rd_addr_o(rd_addr), .array_rd_data_i(rd_data), .page_pow2_o(pow2),
    .sw_prot_en_o(sw_prot)
  );
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  function automatic logic [7:0] amem(input logic [21:0] a);
    return a[7:0] ^ a[17:10];
  endfunction : amem
  always @(posedge clock_i) if (rd_en) rd_data <= amem(rd_addr);
  always @(posedge clock_i) if (op_start === 1'b1) starts <= starts + 1;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk
  task automatic chk_b(input string what, input logic e, input logic g);
    chk(what, {11'h0, e}, {11'h0, g});
  endtask : chk_b
  task report_and_stop;
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic fill(input logic [21:0] a, input logic p2);
    for (int j = 0; j < 4; j++)
    begin
      ex[j] = amem(a);
      a = (!p2 && a[9:0] == 10'h20f) ? {a[21:10] + 12'h1, 10'h0} : a + 22'h1;
    end
  endtask : fill
  task automatic rdx(input logic [7:0] op, input logic [23:0] a, input int n, input logic m3);
    host.frame(op, a, n, m3);
    for (int j = 0; j < n; j++) chk("read byte", {4'h0, ex[j]}, {4'h0, host.rx[j]});
  endtask : rdx
  task automatic wait_op(input logic exp);
    seen = 1'b0;
    for (int n = 0; n < 60 && !seen; n++)
    begin
      @(posedge clock_i);
      #1 seen = starts != taken;
    end
    taken = starts;
    if (exp && !seen)
    begin
      errors++;
      report_and_stop();
    end
  endtask : wait_op
  task automatic done_op;
    @(posedge clock_i);
    #1 op_done_i = 1'b1;
    @(posedge clock_i);
    #1 op_done_i = 1'b0;
    chk_b("busy after done", 1'b0, busy_oe);
  endtask : done_op
  initial
  begin
    seed = 32'h4c;
    errors = 0;
    check_count = 0;
    {rst_n_i, op_done_i, eng_we_i, eng_idx_i, eng_wdata_i, rd_data} = '0;
    wp_n_i = 1'b1;
    ops = '{sfcf_pkg::OP_PROG1, sfcf_pkg::OP_XFER2, sfcf_pkg::OP_CMP1, sfcf_pkg::OP_ER_PAGE,
      sfcf_pkg::OP_ER_BLOCK, sfcf_pkg::OP_ER_SECTOR, sfcf_pkg::OP_ER_CHIP};
    repeat (16) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    for (k = 0; k < 2; k++)
    begin
      for (i = 0; i < 4; i++) host.tx[i] = rnd();
      host.frame(sfcf_pkg::OP_BUF1_WR + 8'(k), 24'h20e, 4, k[0]);
      for (i = 0; i < 4; i++) ex[i] = host.tx[i];
      rdx(sfcf_pkg::OP_BUF1_RD + 8'(k), 24'h20e, 4, !k[0]);
      ex[0] = host.tx[2];
      ex[1] = host.tx[3];
      keep[k] = host.tx[2];
      rdx(sfcf_pkg::OP_BUF1_RD + 8'(k), 24'h0, 2, 1'b0);
    end
    $display("buffer tests done");
    ea = {12'h123, 10'h20e};
    fill(ea, 1'b0);
    rdx(sfcf_pkg::OP_ARR_RD, {2'h0, ea}, 3, 1'b0);
    host.frame(sfcf_pkg::OP_POW2_ON, 24'h0, 0, 1'b1);
    chk_b("page size", 1'b1, pow2);
    ea = 22'h0005ff;
    fill(ea, 1'b1);
    rdx(sfcf_pkg::OP_ARR_RD, {2'h0, ea}, 3, 1'b1);
    host.frame(sfcf_pkg::OP_BUF1_WR, 24'h1ff, 2, 1'b0);
    ex[0] = host.tx[1];
    keep[0] = host.tx[1];
    rdx(sfcf_pkg::OP_BUF1_RD, 24'h0, 1, 1'b1);
    host.frame(sfcf_pkg::OP_POW2_OFF, 24'h0, 0, 1'b0);
    chk_b("page size", 1'b0, pow2);
    $display("array tests done");
    for (k = 0; k < 7; k++)
    begin
      v = rnd();
      pg = {4'h5, v};
      host.frame(ops[k], {2'h0, pg, 10'h0}, 0, v[0]);
      wait_op(1'b1);
      chk("op kind", 12'(k), {9'h0, op_kind});
      chk("op page", pg, op_page);
      if (k < 3) chk_b("op buffer", k == 1, op_buf);
      chk_b("busy", 1'b1, busy_oe);
      if (k == 1)
      begin
        eng_idx_i = 10'h7;
        eng_wdata_i = 8'ha5;
        eng_we_i = 1'b1;
        @(posedge clock_i);
        #1 eng_we_i = 1'b0;
        repeat (2) @(posedge clock_i);
        #1 chk("engine read", 12'h0a5, {4'h0, eng_rdata});
        for (i = 0; i < 2; i++) ex[i] = sfcf_pkg::BLOCKED_BYTE;
        rdx(sfcf_pkg::OP_BUF2_RD, 24'h0, 2, 1'b0);
        rdx(sfcf_pkg::OP_ARR_RD, 24'h0, 2, 1'b1);
        ex[0] = keep[0];
        rdx(sfcf_pkg::OP_BUF1_RD, 24'h0, 1, 1'b0);
      end
      done_op();
    end
    ex[0] = 8'ha5;
    rdx(sfcf_pkg::OP_BUF2_RD, 24'h7, 1, 1'b0);
    $display("operation tests done");
    @(posedge clock_i);
    #1 wp_n_i = 1'b0;
    host.frame(sfcf_pkg::OP_PROG1, 24'h0, 0, 1'b0);
    wait_op(1'b0);
    chk_b("start under protect", 1'b0, seen);
    host.tx[0] = 8'h01;
    host.frame(sfcf_pkg::OP_PROT_WR, 24'h0, 1, 1'b0);
    host.frame(sfcf_pkg::OP_PROT_EN, 24'h0, 0, 1'b1);
    chk_b("soft protect", 1'b1, sw_prot);
    host.frame(sfcf_pkg::OP_LOCK, 24'h040000, 0, 1'b0);
    @(posedge clock_i);
    #1 wp_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    host.frame(sfcf_pkg::OP_ER_PAGE, 24'h0, 0, 1'b0);
    wait_op(1'b1);
    done_op();
    host.frame(sfcf_pkg::OP_ER_PAGE, 24'h040000, 0, 1'b0);
    wait_op(1'b0);
    chk_b("locked erase", 1'b0, seen);
    host.frame(sfcf_pkg::OP_PROT_WR, 24'h0, 1, 1'b0);
    host.frame(sfcf_pkg::OP_ER_PAGE, 24'h0, 0, 1'b1);
    wait_op(1'b0);
    chk_b("protected erase", 1'b0, seen);
    host.frame(sfcf_pkg::OP_PROT_DIS, 24'h0, 0, 1'b0);
    chk_b("soft protect", 1'b0, sw_prot);
    // Flagged sector stays protected by the pin alone
    @(posedge clock_i);
    #1 wp_n_i = 1'b0;
    repeat (4) @(posedge clock_i);
    host.frame(sfcf_pkg::OP_ER_PAGE, 24'h0, 0, 1'b0);
    wait_op(1'b0);
    chk_b("hard protect", 1'b0, seen);
    @(posedge clock_i);
    #1 wp_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    $display("protect tests done");
    host.frame(sfcf_pkg::OP_XFER1, 24'h0, 0, 1'b0);
    wait_op(1'b1);
    #1 rst_n_i = 1'b0;
    #1 chk_b("busy in reset", 1'b0, busy_oe);
    host.tx[0] = 8'h3c;
    host.frame(sfcf_pkg::OP_BUF1_WR, 24'h9, 1, 1'b0);
    chk_b("protect in reset", 1'b0, sw_prot);
    @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    ex[0] = 8'h00;
    rdx(sfcf_pkg::OP_BUF1_RD, 24'h9, 1, 1'b0);
    $display("reset tests done");
    report_and_stop();
  end
endmodule : tb_serial_flash_command_frontend
`default_nettype wire
